// ==== design/timer16_pkg.sv ====
// Package for the 16-bit match/capture timer.
// Assumes an 8-bit register port and a 100 MHz ref_clk.
package timer16_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] CNT_HI_OFS  = 8'hE4; // Count high, read only
  localparam logic [7:0] CNT_LO_OFS  = 8'hE5; // Count low, read only
  localparam logic [7:0] REF_HI_OFS  = 8'hE6; // Reference high
  localparam logic [7:0] REF_LO_OFS  = 8'hE7; // Reference low
  localparam logic [7:0] CTL_OFS     = 8'hE8; // Timer control
  localparam logic [7:0] STAT_OFS    = 8'hE9; // Event status, write one clears
  localparam logic [7:0] MASK_OFS    = 8'hEA; // Event mask

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CTL_SEL_HI = 7;   // Clock select, upper bit
  localparam int CTL_SEL_LO = 6;   // Clock select, lower bit
  localparam int CTL_MOD_HI = 5;   // Mode, upper bit
  localparam int CTL_MOD_LO = 4;   // Mode, lower bit
  localparam int CTL_CLR    = 3;   // Counter clear, write only
  localparam int CTL_OVE    = 2;   // Overflow interrupt enable
  localparam int CTL_MCE    = 1;   // Match/capture interrupt enable
  localparam int CTL_PND    = 0;   // Match/capture pending

  localparam logic [7:0] CTL_RST  = 8'h00; // Control after reset
  localparam logic [7:0] ZERO8    = 8'h00; // Byte reset value
  localparam logic [15:0] CNT_MAX = 16'hFFFF; // Overflow point

  // ----------------------------------------
  // Prescaler masks and vectors
  // ----------------------------------------
  localparam logic [3:0] DIV4_MASK  = 4'h3; // Divide by four
  localparam logic [3:0] DIV8_MASK  = 4'h7; // Divide by eight
  localparam logic [3:0] DIV16_MASK = 4'hF; // Divide by sixteen
  localparam logic [7:0] VEC_OVF    = 8'hF0; // Overflow vector
  localparam logic [7:0] VEC_MC     = 8'hF2; // Match/capture vector

  // Clock select and mode encodings
  typedef enum logic [1:0] {SEL_DIV4, SEL_DIV8, SEL_DIV16, SEL_NEIGH} clk_sel_type;
  typedef enum logic [1:0] {MODE_INTERVAL, MODE_RISE, MODE_FALL, MODE_BOTH} mode_type;

endpackage

// ==== design/timer16.sv ====
// 16-bit up timer with interval match, edge capture and overflow.
// Assumes a bus master on ref_clk, and two pins from other domains.
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
module timer16
  import timer16_pkg::*;
(
  input  wire logic       ref_clk,   // System clock, 100 MHz
  input  wire logic       resetn,    // Asynchronous reset, active low
  input  wire logic       ce,        // Clock enable, freezes all state
  input  wire logic [7:0] addr,      // Register address
  input  wire logic [7:0] wdata,     // Write data
  input  wire logic       wr,        // Write strobe
  input  wire logic       rd,        // Read strobe
  output logic      [7:0] rdata,     // Read data, cycle after rd
  input  wire logic       capture_input_pin,             // Capture pin
  input  wire logic       neighbour_counter_flipflop_out, // Neighbour clock
  output logic            irq,       // Shared timer interrupt level
  output logic      [7:0] vector     // Vector of highest request
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]  ctl_q, ctl_d;       // Control register
  logic [15:0] cnt_q, cnt_d;       // Up counter
  logic [15:0] ref_q, ref_d;       // Reference value
  logic [1:0]  stat_q, stat_d;     // Sticky events: 0 ovf, 1 m/c
  logic [1:0]  mask_q, mask_d;     // Event mask
  logic [3:0]  pre_q, pre_d;       // Oscillator prescaler
  logic [2:0]  nsy_q, nsy_d;       // Neighbour sync and history
  logic [2:0]  csy_q, csy_d;       // Capture sync and history
  logic [7:0]  rdata_q, rdata_d;   // Registered read data
  logic [7:0]  vec_q, vec_d;       // Registered interrupt vector

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  logic        wr_ctl;     // Control write
  logic        tick;       // Timer clock event
  logic        n_rise;     // Neighbour output rising edge
  logic        c_rise;     // Capture pin rising edge
  logic        c_fall;     // Capture pin falling edge
  logic        cap_ev;     // Capture trigger
  logic        ovf_ev;     // Overflow event
  logic        match_ev;   // Match event
  logic        mc_ev;      // Match or capture event
  logic [3:0]  div_mask;   // Selected prescaler mask
  clk_sel_type sel;        // Selected clock
  mode_type    mode;       // Selected mode
  logic [1:0]  req;        // Unmasked, enabled requests

  // Register write decode, used for every writable register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign sel    = clk_sel_type'(ctl_q[CTL_SEL_HI:CTL_SEL_LO]);
  assign mode   = mode_type'(ctl_q[CTL_MOD_HI:CTL_MOD_LO]);
  assign wr_ctl = wr && hit(addr, CTL_OFS);

  // ----------------------------------------
  // Clock source
  // ----------------------------------------
  // select encoding
  always_comb begin
    case (sel)
      SEL_DIV4:  div_mask = DIV4_MASK;
      SEL_DIV8:  div_mask = DIV8_MASK;
      SEL_DIV16: div_mask = DIV16_MASK;
      default:   div_mask = DIV4_MASK;
    endcase
  end

  // Edge detectors read only the settled stages, never stage zero
  assign n_rise = nsy_q[1] && !nsy_q[2];
  assign c_rise = csy_q[1] && !csy_q[2];
  assign c_fall = !csy_q[1] && csy_q[2];

  // neighbour output as tick
  // The neighbour edge is found on ref_clk, so it must stay
  // slower than half of ref_clk to be seen at all.
  assign tick = (sel == SEL_NEIGH) ? n_rise : ((pre_q & div_mask) == div_mask);

  // ----------------------------------------
  // Events
  // ----------------------------------------
  // edge choice
  always_comb begin
    case (mode)
      MODE_RISE: cap_ev = c_rise;
      MODE_FALL: cap_ev = c_fall;
      MODE_BOTH: cap_ev = c_rise || c_fall;
      default:   cap_ev = 1'b0;
    endcase
  end

  assign ovf_ev = tick && (cnt_q == CNT_MAX);

  assign match_ev = tick && (mode == MODE_INTERVAL) && (cnt_q == ref_q) && !ovf_ev;

  assign mc_ev = match_ev || cap_ev;

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // separate enables gate the requests
  assign req = stat_q & mask_q;

  // Level output, high while an unmasked status bit stands
  assign irq = |req;

  // Vector is a flop, picked from next state so it always agrees with irq
  assign vector = vec_q;

  assign rdata = rdata_q;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    ctl_d   = ctl_q;
    cnt_d   = cnt_q;
    ref_d   = ref_q;
    stat_d  = stat_q;
    mask_d  = mask_q;
    pre_d   = pre_q + 4'h1;
    nsy_d   = {nsy_q[1:0], neighbour_counter_flipflop_out};
    csy_d   = {csy_q[1:0], capture_input_pin};
    rdata_d = ZERO8;

    // Counter advances on each timer tick; a match clears it
    if (tick) begin
      cnt_d = cnt_q + 16'h0001;
    end
    if (ovf_ev) begin
      cnt_d = 16'h0000;
    end
    if (match_ev) begin
      cnt_d = 16'h0000;
    end

    // Reference writes, one byte each
    if (wr && hit(addr, REF_HI_OFS)) begin
      ref_d[15:8] = wdata;
    end
    if (wr && hit(addr, REF_LO_OFS)) begin
      ref_d[7:0] = wdata;
    end
    if (cap_ev) begin
      ref_d = cnt_q;
    end

    // Control write; the clear bit never stores
    if (wr_ctl) begin
      ctl_d[7:1] = {wdata[7:4], 1'b0, wdata[2:1]};
      if (!wdata[CTL_PND]) begin
        ctl_d[CTL_PND] = 1'b0;
      end
      if (wdata[CTL_CLR]) begin
        cnt_d = 16'h0000;
      end
    end
    // event sets pending; set beats the clear
    if (mc_ev) begin
      ctl_d[CTL_PND] = 1'b1;
    end

    // Status: write one clears, a new event wins
    if (wr && hit(addr, STAT_OFS)) begin
      stat_d = stat_q & ~wdata[1:0];
    end
    if (ovf_ev && ctl_q[CTL_OVE]) begin
      stat_d[0] = 1'b1;
    end
    if (mc_ev && ctl_q[CTL_MCE]) begin
      stat_d[1] = 1'b1;
    end
    if (wr && hit(addr, MASK_OFS)) begin
      mask_d = wdata[1:0];
    end

    if (stat_d[0] && mask_d[0]) begin
      vec_d = VEC_OVF;
    end else begin
      vec_d = VEC_MC;
    end

    if (rd) begin
      case (addr)
        CNT_HI_OFS: rdata_d = cnt_q[15:8];
        CNT_LO_OFS: rdata_d = cnt_q[7:0];
        REF_HI_OFS: rdata_d = ref_q[15:8];
        REF_LO_OFS: rdata_d = ref_q[7:0];
        CTL_OFS:    rdata_d = ctl_q;
        STAT_OFS:   rdata_d = {6'h00, stat_q};
        MASK_OFS:   rdata_d = {6'h00, mask_q};
        default:    rdata_d = ZERO8;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // control resets to zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_q   <= CTL_RST;
      cnt_q   <= 16'h0000;
      ref_q   <= 16'h0000;
      stat_q  <= 2'b00;
      mask_q  <= 2'b00;
      pre_q   <= 4'h0;
      nsy_q   <= 3'b000;
      csy_q   <= 3'b000;
      rdata_q <= ZERO8;
      vec_q   <= VEC_MC;
    end else if (ce) begin
      ctl_q   <= ctl_d;
      cnt_q   <= cnt_d;
      ref_q   <= ref_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      pre_q   <= pre_d;
      nsy_q   <= nsy_d;
      csy_q   <= csy_d;
      rdata_q <= rdata_d;
      vec_q   <= vec_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Top count, a tick and no clear write
  sequence s_top;
    ce && tick && cnt_q == CNT_MAX && !(wr_ctl && wdata[CTL_CLR]);
  endsequence

  // Control write that clears pending with no event
  sequence s_pnd_clr;
    ce && wr_ctl && !wdata[CTL_PND] && !mc_ev;
  endsequence

  // Falling pin edge in rising-edge mode, nothing pending
  sequence s_fall_in_rise;
    ce && mode == MODE_RISE && c_fall && !ctl_q[CTL_PND];
  endsequence

  a_ovf_wraps: assert property (s_top |=> cnt_q == 16'h0000)
    else $error("counter did not wrap after overflow");

  a_ovf_status: assert property (s_top ##0 ctl_q[CTL_OVE] |=> stat_q[0])
    else $error("overflow not recorded");

  a_clear_write: assert property (ce && wr_ctl && wdata[CTL_CLR] |=> cnt_q == 16'h0000)
    else $error("clear write did not zero counter");

  a_match_clear: assert property (ce && match_ev && !cap_ev |=> cnt_q == 16'h0000 && ctl_q[CTL_PND])
    else $error("match did not clear counter");

  a_no_cap_match: assert property (ce && tick && mode != MODE_INTERVAL && cnt_q == ref_q
      && cnt_q != CNT_MAX && !wr_ctl |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("match acted in capture mode");

  // pending clears on a zero write
  a_pend_clear: assert property (s_pnd_clr |=> !ctl_q[CTL_PND])
    else $error("pending not cleared by write");

  a_ovf_prio: assert property (req == 2'b11 |-> vector == VEC_OVF)
    else $error("overflow lost priority");

  a_cap_copy: assert property (ce && cap_ev |=> ref_q == $past(cnt_q) && ctl_q[CTL_PND])
    else $error("capture did not copy count");

  a_div_four: assert property (ce && sel == SEL_DIV4 && tick ##1 (ce && sel == SEL_DIV4)[*4]
      |-> tick && !$past(tick))
    else $error("divide by four period wrong");

  a_mc_gate: assert property (ce && mc_ev && !ctl_q[CTL_MCE] && !stat_q[1]
      && !(wr && hit(addr, STAT_OFS)) |=> !stat_q[1])
    else $error("disabled match/capture raised status");

  a_pend_set: assert property (ce && mc_ev |=> ctl_q[CTL_PND])
    else $error("event did not set pending");

  a_div_eight: assert property (ce && sel == SEL_DIV8 && tick ##1 (ce && sel == SEL_DIV8)[*8]
      |-> tick && !$past(tick))
    else $error("divide by eight period wrong");

  a_neigh_pulse: assert property (ce && sel == SEL_NEIGH && tick |=> !n_rise)
    else $error("neighbour tick longer than one cycle");

  a_vec_ovf: assert property (req[0] |-> vector == VEC_OVF)
    else $error("overflow vector wrong");

  a_vec_match: assert property (req == 2'b10 |-> vector == VEC_MC)
    else $error("match/capture vector wrong");

  a_clr_reads_zero: assert property (!ctl_q[CTL_CLR])
    else $error("clear bit stored");

  // falling edge ignored in rising mode
  a_rise_only: assert property (s_fall_in_rise |=> !ctl_q[CTL_PND])
    else $error("falling edge captured in rising mode");

  a_irq_level: assert property (stat_q[1] && mask_q[1] |-> irq)
    else $error("interrupt level missing");

  // count low byte read back next cycle
  a_rd_count: assert property (ce && rd && addr == CNT_LO_OFS
      |=> {8'h00, rdata} == ($past(cnt_q) & 16'h00FF))
    else $error("count read data wrong");

  // read data idle without a strobe
  a_rd_idle: assert property (ce && !rd |=> rdata == ZERO8)
    else $error("read data not idle");

  // clock enable low freezes the timer
  a_ce_freeze: assert property (!ce |=> $stable(cnt_q) && $stable(ctl_q) && $stable(stat_q))
    else $error("state moved with clock enable low");

endmodule

// ==== tb/far_side_model.sv ====
// Far-side model: drives the capture pin and the neighbour counter output.
// Assumes the bench steers it with plain levels on ref_clk.
`timescale 1ns/100ps
module far_side_model (
  input  wire logic ref_clk,                        // System clock
  input  wire logic cap_level,                      // Wanted capture pin level
  input  wire logic neigh_run,                      // Neighbour toggles while high
  output logic      capture_input_pin,              // Capture pin
  output logic      neighbour_counter_flipflop_out  // Neighbour flip-flop out
);
  logic [2:0] gap_q;  // Cycles since last toggle

  // ----------------------------------------
  // Pin and neighbour drive
  // ----------------------------------------
  // slow neighbour clock
  // Toggles every 5 cycles, well below the sampling rate; stands low when idle
  always_ff @(posedge ref_clk) begin
    capture_input_pin <= cap_level;
    if (!neigh_run) begin
      gap_q                          <= 3'd0;
      neighbour_counter_flipflop_out <= 1'b0;
    end else if (gap_q == 3'd4) begin
      gap_q                          <= 3'd0;
      neighbour_counter_flipflop_out <= ~neighbour_counter_flipflop_out;
    end else begin
      gap_q <= gap_q + 3'd1;
    end
  end
endmodule

// ==== tb/test_timer16.sv ====
// Self-checking bench for the 16-bit match/capture timer.
// Assumes the register port answers one cycle after a read strobe.
`timescale 1ns/100ps
module test_timer16;
  import timer16_pkg::*;
  logic       ref_clk, resetn, ce, wr, rd, cap_level, neigh_run;
  logic [7:0] addr, wdata, rdata, vector, v, w;
  logic       irq, cap_pin, neigh_out;
  int         err_total, n_compared;

  timer16 timer16_inst (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .capture_input_pin(cap_pin),
    .neighbour_counter_flipflop_out(neigh_out), .irq(irq), .vector(vector));
  far_side_model far_side_model_inst (.ref_clk(ref_clk), .cap_level(cap_level), .neigh_run(neigh_run),
    .capture_input_pin(cap_pin), .neighbour_counter_flipflop_out(neigh_out));

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // Data is taken just after the edge that follows the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Whole run is well under 2000 cycles; a hang ends here
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    final_report();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  // Reset, then one scenario per group of rules, then the verdict
  initial begin
    resetn     = 1'b0;
    ce         = 1'b1;
    wr         = 1'b0;
    rd         = 1'b0;
    addr       = 8'h00;
    wdata      = 8'h00;
    cap_level  = 1'b0;
    neigh_run  = 1'b0;
    err_total  = 0;
    n_compared = 0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_reg(CTL_OFS, v);
    check("ctl reset", v, 8'h00);
    rd_reg(REF_HI_OFS, v);
    check("ref hi reset", v, 8'h00);
    check("irq reset", {7'h00, irq}, 8'h00);
    // Reference bytes are read/write, count bytes refuse writes
    wr_reg(REF_HI_OFS, 8'hA5);
    wr_reg(REF_LO_OFS, 8'h5A);
    rd_reg(REF_HI_OFS, v);
    check("ref hi", v, 8'hA5);
    rd_reg(REF_LO_OFS, v);
    check("ref lo", v, 8'h5A);
    wr_reg(CTL_OFS, 8'h08);
    wr_reg(CNT_HI_OFS, 8'hFF);
    rd_reg(CNT_HI_OFS, v);
    check("count hi ro", v, 8'h00);
    rd_reg(8'hF0, v);
    check("unmapped", v, 8'h00);
    // Interval match at 0002 with match interrupt enabled
    wr_reg(REF_HI_OFS, 8'h00);
    wr_reg(REF_LO_OFS, 8'h02);
    wr_reg(MASK_OFS, 8'h02);
    wr_reg(CTL_OFS, 8'h0A);
    repeat (20) @(posedge ref_clk);
    rd_reg(CTL_OFS, v);
    check("match pending", v, 8'h03);
    check("irq match", {7'h00, irq}, 8'h01);
    check("vector match", vector, VEC_MC);
    rd_reg(CNT_LO_OFS, v);
    check("count cleared", {7'h00, v <= 8'h02}, 8'h01);
    wr_reg(MASK_OFS, 8'h00);
    #1;
    check("irq masked", {7'h00, irq}, 8'h00);
    wr_reg(MASK_OFS, 8'h02);
    // Capture mode: no match, pending cleared by writing zero
    wr_reg(CTL_OFS, 8'h12);
    wr_reg(STAT_OFS, 8'h02);
    #1;
    check("irq cleared", {7'h00, irq}, 8'h00);
    repeat (40) @(posedge ref_clk);
    rd_reg(CTL_OFS, v);
    check("no match", v, 8'h12);
    rd_reg(CNT_LO_OFS, v);
    check("count runs", {7'h00, v > 8'h02}, 8'h01);
    // Every capture mode against both pin edges, enable bit off
    for (int m = 1; m < 4; m++) begin
      wr_reg(REF_HI_OFS, 8'h00);
      wr_reg(REF_LO_OFS, 8'h00);
      wr_reg(CTL_OFS, {2'b00, m[1:0], 4'h0});
      cap_level <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd_reg(CTL_OFS, v);
      check("rise pend", {7'h00, v[0]}, {7'h00, m[0]});
      check("irq gated", {7'h00, irq}, 8'h00);
      rd_reg(REF_LO_OFS, v);
      rd_reg(REF_HI_OFS, w);
      check("rise copy", {7'h00, (v | w) != 8'h00}, {7'h00, m[0]});
      wr_reg(CTL_OFS, {2'b00, m[1:0], 4'h0});
      cap_level <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rd_reg(CTL_OFS, v);
      check("fall pend", {7'h00, v[0]}, {7'h00, m[1]});
    end
    // Clock enable low for 40 cycles: at most one tick may slip through
    rd_reg(CNT_LO_OFS, v);
    @(posedge ref_clk);
    ce <= 1'b0;
    repeat (40) @(posedge ref_clk);
    ce <= 1'b1;
    rd_reg(CNT_LO_OFS, w);
    check("ce freeze", {7'h00, (w - v) <= 8'd1}, 8'h01);
    // Tick rate of each clock select over 160 cycles
    for (int s = 0; s < 4; s++) begin
      neigh_run <= (s == 3);
      wr_reg(CTL_OFS, {s[1:0], 2'b01, 4'h8});
      repeat (160) @(posedge ref_clk);
      rd_reg(CNT_LO_OFS, v);
      w = (s == 3) ? 8'd16 : 8'd160 >> (s + 2);
      check("tick rate", {7'h00, v + 8'd2 >= w && v <= w + 8'd2}, 8'h01);
    end
    final_report();
  end
endmodule
